/* File: pkg/lfw_pkg.sv */
// constants, types and helper functions of the level filter and wave window block
// Operation
// - report maximum, mean and median level over the wave analysis window
// - point-to-point link defaults to 115200, multi-drop link to 9600 baud
// - sentence suppression defaults 0; value 2 drops only the angle report
// - answer a Modbus request only when its address matches the slave id
// - answer an SDI-12 request only when its address matches ours
// - parity none, odd or even; odd sets bit on odd ones, even on even
// - drop received bytes whose parity bit disagrees; even is the default
// - one or two stop bits after each Modbus byte, one by default
// - current output maps configured minimum to 4 mA, maximum to 20 mA
// - filter type none passes raw readings straight through
// - IIR smoothing constant 0..1, larger gives faster response
// - moving average over the last filter-length readings
// - median of the last filter-length readings
// - drop 20% outliers of the last filter-length readings, average the rest
// - report distance 0 when the peak amplitude does not exceed the threshold
// - peak detector selects maximum peak (default) or last peak
// - wave length 0..3600 samples; zero disables wave computation
// - window seconds equal the sample count divided by 10
// - use all samples until the window fills, then drop the oldest
// - outside SDI-12 mode wave results are offered from the first sample
// - in SDI-12 mode the wave length sets the returned measurement duration
package lfw_pkg;
   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] A_FILT = 8'h00;
   localparam logic [7:0] A_WAVE = 8'h04;
   localparam logic [7:0] A_LINK = 8'h08;
   localparam logic [7:0] A_IDS = 8'h0C;
   localparam logic [7:0] A_CMIN = 8'h10;
   localparam logic [7:0] A_CMAX = 8'h14;
   localparam logic [7:0] A_THR = 8'h18;
   localparam logic [7:0] A_LEVEL = 8'h20;
   localparam logic [7:0] A_WMAX = 8'h24;
   localparam logic [7:0] A_WMEAN = 8'h28;
   localparam logic [7:0] A_WMED = 8'h2C;
   localparam logic [7:0] A_STAT = 8'h30;
   localparam logic [7:0] A_CODE = 8'h34;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int F_FLEN = 8;
   localparam int F_IIRK = 16;
   localparam int F_B485 = 4;
   localparam int F_SUPP = 8;
   localparam int F_PAR = 12;
   localparam int F_STOP2 = 16;
   localparam int F_PKLAST = 17;
   localparam int F_SDI = 18;
   localparam int F_SDIID = 8;
   localparam int F_BUSY = 16;
   localparam int F_WVAL = 17;
   // ----------------------------------------
   // sizes and reset values
   // ----------------------------------------
   localparam logic [11:0] DEPTH = 12'hE10;
   localparam logic [11:0] SAMPLES_PER_S = 12'h00A;
   localparam logic [2:0] R_FTYPE = 3'h0;
   localparam logic [5:0] R_FLEN = 6'h0A;
   localparam logic [7:0] R_IIRK = 8'h80;
   localparam logic [11:0] R_WLEN = 12'h258;
   localparam logic [2:0] R_B232 = 3'h7;
   localparam logic [2:0] R_B485 = 3'h3;
   localparam logic [3:0] R_SUPP = 4'h0;
   localparam logic [3:0] SUPP_ANG = 4'h2;
   localparam logic [7:0] R_MBID = 8'h01;
   localparam logic [7:0] R_SDIID = 8'h30;
   localparam logic [15:0] R_CMIN = 16'h0000;
   localparam logic [15:0] R_CMAX = 16'hFFFF;
   localparam logic [15:0] R_THR = 16'h0000;
   localparam logic [15:0] CODE_FULL = 16'hFFFF;
   // ----------------------------------------
   // enumerations
   // ----------------------------------------
   typedef enum logic [2:0] {
      FT_NONE = 3'h0, FT_IIR = 3'h1, FT_AVG = 3'h2, FT_MED = 3'h3, FT_TRIM = 3'h4
   } lfw_filt_e;
   typedef enum logic [1:0] {PAR_NONE = 2'h0, PAR_ODD = 2'h1, PAR_EVEN = 2'h2} lfw_par_e;
   localparam lfw_par_e R_PAR = PAR_EVEN;
   typedef enum logic [1:0] {S_IDLE = 2'h0, S_SCAN = 2'h1, S_DIV = 2'h2, S_FIN = 2'h3} lfw_state_e;
   // ----------------------------------------
   // functions
   // ----------------------------------------
   function automatic logic par_bit(input logic [1:0] mode, input logic [7:0] b);
      par_bit = (mode == PAR_ODD) ? ^b : ((mode == PAR_EVEN) ? ~^b : 1'b0);
   endfunction
   function automatic logic [11:0] wrap(input logic [12:0] a);
      wrap = (a >= {1'b0, DEPTH}) ? 12'(a - {1'b0, DEPTH}) : a[11:0];
   endfunction
endpackage

/* File: hw/lfw_ram.sv */
// sample window memory with registered read data
module lfw_ram (
   input wire logic pclk,
   input wire logic we,
   input wire logic [11:0] waddr,
   input wire logic [15:0] wdata,
   input wire logic [11:0] raddr,
   output logic [15:0] rdata
);
   logic [15:0] mem [0:4095];

   always_ff @(posedge pclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule

/* File: hw/lfw_top.sv */
// level filter, wave window statistics and link settings with APB registers
//
// Our own choices: the APB register port and the register offsets.
module lfw_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic samp_valid,
   input wire logic [15:0] max_pk_dist,
   input wire logic [15:0] max_pk_amp,
   input wire logic [15:0] last_pk_dist,
   input wire logic [15:0] last_pk_amp,
   output logic [15:0] level_out,
   output logic level_valid,
   output logic [15:0] cur_code,
   output logic [15:0] wave_max,
   output logic [15:0] wave_mean,
   output logic [15:0] wave_med,
   output logic wave_valid,
   output logic [8:0] wave_secs,
   output logic [2:0] rs232_rate,
   output logic [2:0] rs485_rate,
   output logic [3:0] nmea_suppress,
   output logic angle_report_sentence_en,
   output logic [1:0] parity_mode,
   output logic stop_two,
   input wire logic mb_req_valid,
   input wire logic [7:0] mb_req_addr,
   output logic mb_answer,
   input wire logic sdi_req_valid,
   input wire logic [7:0] sdi_req_addr,
   output logic sdi_answer,
   input wire logic [7:0] tx_byte,
   output logic tx_parity,
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   input wire logic rx_par,
   output logic rx_accept,
   output logic rx_drop
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      lfw_pkg::lfw_filt_e ftype;
      logic [5:0] flen;
      logic [7:0] iirk;
      logic [11:0] wlen;
      logic [2:0] b232;
      logic [2:0] b485;
      logic [3:0] supp;
      logic ang_en;
      lfw_pkg::lfw_par_e par;
      logic stop2;
      logic pk_last;
      logic sdi_mode;
      logic [7:0] mbid;
      logic [7:0] sdiid;
      logic [15:0] cmin;
      logic [15:0] cmax;
      logic [15:0] thr;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      lfw_pkg::lfw_state_e st;
      logic [11:0] wp;
      logic [11:0] fill;
      logic [15:0] x;
      logic job;
      logic [2:0] step;
      logic [11:0] n;
      logic [11:0] base;
      logic [11:0] idx;
      logic rv;
      logic [11:0] k;
      logic [15:0] res;
      logic [3:0] bitn;
      logic [11:0] cnt;
      logic [31:0] sum;
      logic [15:0] mx;
      logic [15:0] lo;
      logic [15:0] hi;
      logic [31:0] tsum;
      logic [11:0] tcnt;
      logic [31:0] dq;
      logic [16:0] drem;
      logic [15:0] dden;
      logic [5:0] dcnt;
      logic [15:0] mean;
      logic [15:0] med;
      logic [15:0] trim;
      logic [15:0] iir;
      logic [15:0] level;
      logic lvl_v;
      logic [15:0] code;
      logic [15:0] wmax;
      logic [15:0] wmean;
      logic [15:0] wmed;
      logic wvalid;
      logic [8:0] wsecs;
      logic mb_ans;
      logic sdi_ans;
      logic txp;
      logic rx_ok;
      logic rx_bad;
   } lfw_st_s;

   lfw_st_s q;
   lfw_st_s d;
   logic [15:0] rdata;
   logic [15:0] gated;
   logic ram_we;

   lfw_ram u_ram (
      .pclk(pclk),
      .we(ram_we),
      .waddr(q.wp),
      .wdata(gated),
      .raddr(lfw_pkg::wrap({1'b0, q.base} + {1'b0, q.idx})),
      .rdata(rdata)
   );

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      logic pv;
      logic hit;
      logic [31:0] rmux;
      logic [7:0] a;
      logic [15:0] cand;
      logic [15:0] v;
      logic [11:0] nf;
      logic [24:0] mix;
      d = q;
      pv = psel & penable;
      a = paddr[7:0];
      hit = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'h0);
      rmux = 32'h0000_0000;
      cand = 16'(q.res | (16'h0001 << q.bitn));
      v = 16'h0000;
      nf = 12'h000;
      mix = 25'h0000000;
      ram_we = 1'b0;
      // peak detector choice and amplitude gate
      gated = q.pk_last ? last_pk_dist : max_pk_dist;
      if ((q.pk_last ? last_pk_amp : max_pk_amp) <= q.thr) begin
         gated = 16'h0000;
      end
      // ----------------------------------------
      // apb slave, one wait state
      // ----------------------------------------
      unique case (a)
         lfw_pkg::A_FILT: rmux = {8'h00, q.iirk, 2'h0, q.flen, 5'h00, q.ftype};
         lfw_pkg::A_WAVE: rmux = {20'h00000, q.wlen};
         lfw_pkg::A_LINK: rmux = {13'h0000, q.sdi_mode, q.pk_last, q.stop2, 2'h0, q.par,
                                  q.supp, 1'b0, q.b485, 1'b0, q.b232};
         lfw_pkg::A_IDS: rmux = {16'h0000, q.sdiid, q.mbid};
         lfw_pkg::A_CMIN: rmux = {16'h0000, q.cmin};
         lfw_pkg::A_CMAX: rmux = {16'h0000, q.cmax};
         lfw_pkg::A_THR: rmux = {16'h0000, q.thr};
         lfw_pkg::A_LEVEL: rmux = {16'h0000, q.level};
         lfw_pkg::A_WMAX: rmux = {16'h0000, q.wmax};
         lfw_pkg::A_WMEAN: rmux = {16'h0000, q.wmean};
         lfw_pkg::A_WMED: rmux = {16'h0000, q.wmed};
         lfw_pkg::A_STAT: rmux = {14'h0000, q.wvalid, q.st != lfw_pkg::S_IDLE, 4'h0, q.fill};
         lfw_pkg::A_CODE: rmux = {16'h0000, q.code};
         default: hit = 1'b0;
      endcase
      d.pready = pv & ~q.pready;
      if (pv & ~q.pready) begin
         d.prdata = (hit & ~pwrite) ? rmux : 32'h0000_0000;
         d.pslverr = ~hit;
      end
      if (pv & q.pready & pwrite & hit) begin
         unique case (a)
            lfw_pkg::A_FILT: begin
               d.ftype = lfw_pkg::lfw_filt_e'(pwdata[2:0]);
               d.flen = pwdata[lfw_pkg::F_FLEN +: 6];
               d.iirk = pwdata[lfw_pkg::F_IIRK +: 8];
            end
            lfw_pkg::A_WAVE: begin
               d.wlen = (pwdata[31:0] > {20'h00000, lfw_pkg::DEPTH}) ? lfw_pkg::DEPTH
                        : pwdata[11:0];
            end
            lfw_pkg::A_LINK: begin
               d.b232 = pwdata[2:0];
               d.b485 = pwdata[lfw_pkg::F_B485 +: 3];
               d.supp = pwdata[lfw_pkg::F_SUPP +: 4];
               d.par = lfw_pkg::lfw_par_e'(pwdata[lfw_pkg::F_PAR +: 2]);
               d.stop2 = pwdata[lfw_pkg::F_STOP2];
               d.pk_last = pwdata[lfw_pkg::F_PKLAST];
               d.sdi_mode = pwdata[lfw_pkg::F_SDI];
            end
            lfw_pkg::A_IDS: begin
               d.mbid = pwdata[7:0];
               d.sdiid = pwdata[lfw_pkg::F_SDIID +: 8];
            end
            lfw_pkg::A_CMIN: d.cmin = pwdata[15:0];
            lfw_pkg::A_CMAX: d.cmax = pwdata[15:0];
            lfw_pkg::A_THR: d.thr = pwdata[15:0];
            default: d.thr = q.thr;
         endcase
      end
      d.ang_en = d.supp != lfw_pkg::SUPP_ANG;
      d.wsecs = 9'(d.wlen / lfw_pkg::SAMPLES_PER_S);
      // ----------------------------------------
      // link address match and parity
      // ----------------------------------------
      d.mb_ans = mb_req_valid & (mb_req_addr == q.mbid);
      d.sdi_ans = sdi_req_valid & (sdi_req_addr == q.sdiid);
      d.txp = lfw_pkg::par_bit(q.par, tx_byte);
      d.rx_ok = rx_valid & ((q.par == lfw_pkg::PAR_NONE)
                | (rx_par == lfw_pkg::par_bit(q.par, rx_byte)));
      d.rx_bad = rx_valid & ~d.rx_ok;
      // ----------------------------------------
      // sample engine
      // ----------------------------------------
      d.lvl_v = 1'b0;
      unique case (q.st)
         lfw_pkg::S_IDLE: begin
            if (samp_valid) begin
               ram_we = 1'b1;
               d.x = gated;
               d.wp = lfw_pkg::wrap({1'b0, q.wp} + 13'h0001);
               d.fill = (q.fill == lfw_pkg::DEPTH) ? q.fill : 12'(q.fill + 12'h001);
               nf = (q.flen == 6'h00) ? 12'h001 : {6'h00, q.flen};
               d.n = (nf < d.fill) ? nf : d.fill;
               d.base = lfw_pkg::wrap({1'b0, d.wp} + {1'b0, lfw_pkg::DEPTH} - {1'b0, d.n});
               d.job = 1'b0;
               d.step = 3'h0;
               d.idx = 12'h000;
               d.rv = 1'b0;
               d.sum = 32'h0000_0000;
               d.mx = 16'h0000;
               d.st = lfw_pkg::S_SCAN;
            end
         end
         lfw_pkg::S_SCAN: begin
            d.rv = q.idx < q.n;
            if (q.idx < q.n) begin
               d.idx = 12'(q.idx + 12'h001);
            end
            if (q.rv) begin
               d.sum = 32'(q.sum + {16'h0000, rdata});
               d.mx = (rdata > q.mx) ? rdata : q.mx;
               d.cnt = (rdata < cand) ? 12'(q.cnt + 12'h001) : q.cnt;
               if ((rdata >= q.lo) && (rdata <= q.hi)) begin
                  d.tsum = 32'(q.tsum + {16'h0000, rdata});
                  d.tcnt = 12'(q.tcnt + 12'h001);
               end
            end
            if ((q.idx == q.n) && !q.rv) begin
               d.idx = 12'h000;
               d.cnt = 12'h000;
               d.st = lfw_pkg::S_SCAN;
               if (q.step == 3'h0) begin
                  d.dq = q.sum;
                  d.dden = {4'h0, q.n};
                  d.drem = 17'h00000;
                  d.dcnt = 6'h00;
                  d.st = lfw_pkg::S_DIV;
               end else if (q.step == 3'h4) begin
                  d.dq = q.tsum;
                  d.dden = {4'h0, q.tcnt};
                  d.drem = 17'h00000;
                  d.dcnt = 6'h00;
                  d.st = lfw_pkg::S_DIV;
               end else begin
                  // bisection select of the k-th smallest value
                  if (q.cnt <= q.k) begin
                     d.res = cand;
                  end
                  d.bitn = 4'(q.bitn - 4'h1);
                  if (q.bitn == 4'h0) begin
                     d.res = 16'h0000;
                     d.bitn = 4'hF;
                     d.step = 3'(q.step + 3'h1);
                     unique case (q.step)
                        3'h1: begin
                           d.med = (q.cnt <= q.k) ? cand : q.res;
                           d.k = 12'(q.n / 12'h00A);
                           if (q.job || (q.ftype != lfw_pkg::FT_TRIM)) begin
                              d.st = lfw_pkg::S_FIN;
                           end
                        end
                        3'h2: begin
                           d.lo = (q.cnt <= q.k) ? cand : q.res;
                           d.k = 12'(q.n - 12'h001 - q.n / 12'h00A);
                        end
                        default: begin
                           d.hi = (q.cnt <= q.k) ? cand : q.res;
                           d.tsum = 32'h0000_0000;
                           d.tcnt = 12'h000;
                        end
                     endcase
                  end
               end
            end
         end
         lfw_pkg::S_DIV: begin
            // restoring divide, quotient shifts into dq
            d.drem = {q.drem[15:0], q.dq[31]};
            d.dq = {q.dq[30:0], 1'b0};
            if (d.drem >= {1'b0, q.dden}) begin
               d.drem = 17'(d.drem - {1'b0, q.dden});
               d.dq[0] = 1'b1;
            end
            d.dcnt = 6'(q.dcnt + 6'h01);
            if (q.dcnt == 6'h1F) begin
               d.st = lfw_pkg::S_SCAN;
               d.step = 3'(q.step + 3'h1);
               d.res = 16'h0000;
               d.bitn = 4'hF;
               d.k = 12'(12'(q.n - 12'h001) >> 1);
               if (q.step == 3'h0) begin
                  d.mean = d.dq[15:0];
               end else if (q.step == 3'h4) begin
                  d.trim = d.dq[15:0];
                  d.st = lfw_pkg::S_FIN;
               end else begin
                  d.code = d.dq[15:0];
                  d.st = lfw_pkg::S_FIN;
               end
            end
         end
         lfw_pkg::S_FIN: begin
            if (q.job) begin
               d.wmax = q.mx;
               d.wmean = q.mean;
               d.wmed = q.med;
               d.wvalid = ~q.sdi_mode | (q.fill >= q.wlen);
               d.st = lfw_pkg::S_IDLE;
            end else begin
               if (q.step != 3'h6) begin
                  mix = 25'({9'h000, q.iir} * {1'b0, 8'(~q.iirk)}
                        + {9'h000, q.x} * {1'b0, q.iirk});
                  d.iir = (q.fill == 12'h001) ? q.x : mix[23:8];
                  unique case (q.ftype)
                     lfw_pkg::FT_IIR: v = d.iir;
                     lfw_pkg::FT_AVG: v = q.mean;
                     lfw_pkg::FT_MED: v = q.med;
                     lfw_pkg::FT_TRIM: v = q.trim;
                     default: v = q.x;
                  endcase
                  d.level = v;
                  d.lvl_v = 1'b1;
                  d.step = 3'h6;
                  if (v <= q.cmin) begin
                     d.code = 16'h0000;
                  end else if (v >= q.cmax) begin
                     d.code = lfw_pkg::CODE_FULL;
                  end else begin
                     d.dq = 32'({16'h0000, 16'(v - q.cmin)} * {16'h0000, lfw_pkg::CODE_FULL});
                     d.dden = 16'(q.cmax - q.cmin);
                     d.drem = 17'h00000;
                     d.dcnt = 6'h00;
                     d.step = 3'h5;
                     d.st = lfw_pkg::S_DIV;
                  end
               end else if (q.wlen == 12'h000) begin
                  d.wvalid = 1'b0;
                  d.st = lfw_pkg::S_IDLE;
               end else begin
                  d.job = 1'b1;
                  d.step = 3'h0;
                  d.n = (q.wlen < q.fill) ? q.wlen : q.fill;
                  d.base = lfw_pkg::wrap({1'b0, q.wp} + {1'b0, lfw_pkg::DEPTH} - {1'b0, d.n});
                  d.idx = 12'h000;
                  d.rv = 1'b0;
                  d.sum = 32'h0000_0000;
                  d.mx = 16'h0000;
                  d.st = lfw_pkg::S_SCAN;
               end
            end
         end
      endcase
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.ftype <= lfw_pkg::lfw_filt_e'(lfw_pkg::R_FTYPE);
         q.flen <= lfw_pkg::R_FLEN;
         q.iirk <= lfw_pkg::R_IIRK;
         q.wlen <= lfw_pkg::R_WLEN;
         q.b232 <= lfw_pkg::R_B232;
         q.b485 <= lfw_pkg::R_B485;
         q.supp <= lfw_pkg::R_SUPP;
         q.ang_en <= 1'b1;
         q.par <= lfw_pkg::R_PAR;
         q.mbid <= lfw_pkg::R_MBID;
         q.sdiid <= lfw_pkg::R_SDIID;
         q.cmin <= lfw_pkg::R_CMIN;
         q.cmax <= lfw_pkg::R_CMAX;
         q.thr <= lfw_pkg::R_THR;
         q.wsecs <= 9'h03C;
         q.st <= lfw_pkg::S_IDLE;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign level_out = q.level;
   assign level_valid = q.lvl_v;
   assign cur_code = q.code;
   assign wave_max = q.wmax;
   assign wave_mean = q.wmean;
   assign wave_med = q.wmed;
   assign wave_valid = q.wvalid;
   assign wave_secs = q.wsecs;
   assign rs232_rate = q.b232;
   assign rs485_rate = q.b485;
   assign nmea_suppress = q.supp;
   assign angle_report_sentence_en = q.ang_en;
   assign parity_mode = q.par;
   assign stop_two = q.stop2;
   assign mb_answer = q.mb_ans;
   assign sdi_answer = q.sdi_ans;
   assign tx_parity = q.txp;
   assign rx_accept = q.rx_ok;
   assign rx_drop = q.rx_bad;
endmodule

/* File: tb/lfw_monitor.sv */
// port checker of the level filter block
module lfw_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic mb_req_valid,
   input wire logic mb_answer,
   input wire logic sdi_req_valid,
   input wire logic sdi_answer,
   input wire logic [7:0] tx_byte,
   input wire logic tx_parity,
   input wire logic [1:0] parity_mode,
   input wire logic rx_valid,
   input wire logic rx_accept,
   input wire logic rx_drop,
   input wire logic [3:0] nmea_suppress,
   input wire logic angle_report_sentence_en,
   input wire logic wave_valid,
   input wire logic [15:0] wave_max,
   input wire logic [15:0] wave_mean,
   input wire logic [15:0] wave_med
);
   // ---
   // assertions
   // ---
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_mb_cause: assert property (mb_answer |-> $past(mb_req_valid))
      else $error("modbus answer without request");
   a_sdi_cause: assert property (sdi_answer |-> $past(sdi_req_valid))
      else $error("sdi answer without request");
   a_odd_parity: assert property (parity_mode == 2'h1 |=> tx_parity == ^$past(tx_byte))
      else $error("odd parity bit wrong");
   a_even_parity: assert property (parity_mode == 2'h2 |=> tx_parity == ~^$past(tx_byte))
      else $error("even parity bit wrong");
   a_rx_verdict: assert property (rx_valid |=> rx_accept ^ rx_drop)
      else $error("received byte not judged once");
   a_none_accepts: assert property (rx_valid && parity_mode == 2'h0 |=> rx_accept)
      else $error("byte refused without parity");
   a_angle_flag: assert property (angle_report_sentence_en == (nmea_suppress != 4'h2))
      else $error("angle sentence flag wrong");
   a_wave_order: assert property (wave_valid |-> wave_max >= wave_mean && wave_max >= wave_med)
      else $error("window maximum below mean or median");
endmodule
bind lfw_top lfw_monitor u_mon (.*);

/* File: tb/lfw_front_model.sv */
// radar front end model handing peak candidates to the block
module lfw_front_model (
   input wire logic pclk,
   output logic samp_valid,
   output logic [15:0] max_pk_dist,
   output logic [15:0] max_pk_amp,
   output logic [15:0] last_pk_dist,
   output logic [15:0] last_pk_amp
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      samp_valid = 1'b0;
      {max_pk_dist, max_pk_amp, last_pk_dist, last_pk_amp} = 64'h0;
   end
   // one reading pulse; lines show inverted data once it is gone
   task automatic send(input logic [15:0] md, ma, ld, la);
      @(posedge pclk);
      samp_valid <= 1'b1;
      {max_pk_dist, max_pk_amp, last_pk_dist, last_pk_amp} <= {md, ma, ld, la};
      @(posedge pclk);
      samp_valid <= 1'b0;
      {max_pk_dist, max_pk_amp, last_pk_dist, last_pk_amp} <= ~{md, ma, ld, la};
   endtask
endmodule

/* File: tb/level_filter_wave_window_tb_top.sv */
// self-checking bench of the level filter block
module level_filter_wave_window_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, r;
   logic [15:0] max_pk_dist, max_pk_amp, last_pk_dist, last_pk_amp, level_out, cur_code;
   logic [15:0] wave_max, wave_mean, wave_med;
   logic [8:0] wave_secs;
   logic [2:0] rs232_rate, rs485_rate;
   logic [3:0] nmea_suppress;
   logic [1:0] parity_mode;
   logic [7:0] mb_req_addr = 0, sdi_req_addr = 0, tx_byte = 0, rx_byte = 0;
   logic mb_req_valid = 0, sdi_req_valid = 0, rx_valid = 0, rx_par = 0, samp_valid;
   logic level_valid, wave_valid, angle_report_sentence_en, stop_two, mb_answer;
   logic sdi_answer, tx_parity, rx_accept, rx_drop;
   int errors = 0, tests_run = 0, cyc = 0, n, x, k, seed = 32'h9A95DE59;
   int q[$];
   logic [7:0] ra[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14};
   logic [31:0] rv[5] = '{32'h00800A00, 32'h258, 32'h2037, 32'h3001, 32'hFFFF};
   logic [2:0] fm[4] = '{3'h0, 3'h2, 3'h3, 3'h4};
   lfw_top dut (.*);
   lfw_front_model front (.*);
   always #50 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         errors++;
         stop_test();
      end
   end
   // ---
   // helpers
   // ---
   task automatic stop_test();
      $display("errors %0d checks %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string s, input logic [63:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", s, exp, got);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, 4'h0, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      {rd, er} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   endtask
   function automatic logic pb(int m, logic [7:0] b);
      return m == 1 ? ^b : m == 2 ? ~^b : 1'b0;
   endfunction
   function automatic int stat(int c, int t);
      int w[$];
      int s;
      s = 0;
      for (int j = q.size() - c; j < q.size(); j++) w.push_back(q[j]);
      w.sort();
      foreach (w[j]) s += w[j];
      return t == 0 ? w[c - 1] : t == 1 ? s / c : w[(c - 1) / 2];
   endfunction
   // ---
   // scenarios
   // ---
   initial begin
      repeat (10) @(posedge pclk);
      chk("reset outs", {rs232_rate, rs485_rate, parity_mode, stop_two}, 9'h1DC);
      chk("reset secs", {angle_report_sentence_en, wave_secs}, 10'h23C);
      presetn <= 1'b1;
      foreach (ra[i]) begin
         bus(1'b0, ra[i], 32'h0);
         chk("reset reg", rd, rv[i]);
      end
      bus(1'b0, 8'h1C, 32'h0);
      chk("unmapped", {er, rd}, 33'h100000000);
      bus(1'b1, 8'h04, 32'h0FA0);
      bus(1'b0, 8'h04, 32'h0);
      chk("wave len", {wave_secs, rd}, {9'h168, 32'hE10});
      foreach (rv[i]) bus(1'b1, i ? 8'h08 + 8'(i * 4) : 8'h04,
         32'({32'h3, 32'h2211, 32'hE10, 32'h20D0, 32'h3000} >> (128 - i * 32)));
      for (k = 0; k < 3; k++) begin
         bus(1'b1, 8'h08, 32'h37 | k << 12 | k << 8 | (k % 2) << 16);
         @(negedge pclk);
         chk("link", {parity_mode, stop_two, nmea_suppress, angle_report_sentence_en},
            {k[1:0], k[0], k[3:0], k != 2});
         repeat (6) begin
            r = $random(seed);
            @(posedge pclk);
            {tx_byte, rx_byte, rx_par} <= r[16:0];
            mb_req_addr <= r[17] ? 8'h11 : r[31:24];
            sdi_req_addr <= r[18] ? 8'h22 : r[31:24];
            {mb_req_valid, sdi_req_valid, rx_valid} <= 3'h7;
            @(posedge pclk);
            {mb_req_valid, sdi_req_valid, rx_valid} <= 3'h0;
            @(negedge pclk);
            chk("tx par", tx_parity, pb(k, r[16:9]));
            chk("rx", {rx_accept, rx_drop}, (k == 0 || r[0] == pb(k, r[8:1])) ? 2 : 1);
            chk("ids", {mb_answer, sdi_answer}, {mb_req_addr == 8'h11, sdi_req_addr == 8'h22});
         end
      end
      for (k = 0; k < 24; k++) begin
         r = $random(seed);
         bus(1'b1, 8'h08, 32'h2037 | 32'(r[28]) << 17);
         bus(1'b1, 8'h00, 32'h00800400 | fm[r[30:29]]);
         front.send(16'(12 * r[9:0]), {r[23:20], 12'h0}, 16'(12 * r[19:10]), {r[27:24], 12'h0});
         x = r[28] ? (r[27:24] > 3 ? 12 * r[19:10] : 0) : (r[23:20] > 3 ? 12 * r[9:0] : 0);
         q.push_back(x);
         n = 0;
         do @(posedge pclk); while (level_valid !== 1'b1 && ++n < 9000);
         n = q.size() < 4 ? q.size() : 4;
         chk("level", level_out, r[30:29] == 0 ? x : stat(n, r[30:29] == 2 ? 2 : 1));
         do bus(1'b0, 8'h30, 32'h0); while (rd[16] !== 1'b0);
         n = q.size() < 3 ? q.size() : 3;
         chk("wave", {wave_max, wave_mean, wave_med, wave_valid},
            {16'(stat(n, 0)), 16'(stat(n, 1)), 16'(stat(n, 2)), 1'b1});
         chk("code", cur_code, level_out <= 16'h0E10 ? 64'h0 : level_out >= 16'h20D0 ? 64'hFFFF
            : 64'((int'(level_out) - 3600) * 65535 / 4800));
      end
      chk("secs", wave_secs, 9'h0);
      stop_test();
   end
endmodule
